// file: core/sqs_quick_stop.sv
// Purpose: Quick stop handling in the drive's power drive state machine.
// Assumes: Motion profile logic reports standstill; alarm logic flags events.
// Notes: All inputs are synchronous to ref_clk except forced_stop_input_two and the asynchronous reset rst.
//
// Notes on behaviour
// - Quick stop bit cleared: decelerate per option code, then servo-off or hold.
// - Quick stop is accepted only in Operation Enabled.
// - Forced stop deceleration disabled means dynamic brake for any code.
// - Torque modes and continuous-to-torque stop with dynamic brake at once.
// - Forced stop alarm during stop: Fault Reaction Active, finish, servo-off.
// - Forced stop warning during stop: stay Quick Stop Active, then servo-off.
// - Quick stop warning during stop: use its decel time, then servo-off.
// - A controller command stop wins and applies the dynamic brake.
// - Quick stop works in every listed position, velocity, torque and tool mode.
// - Time-constant setting in ms, initial value 100.
// - Rate setting in command units per second squared, initial value 0.
// - Method codes 0,1,2,5,6 decoded; default is 2.
// - Second forced stop input always behaves as code 2.
// - Method selector and option code object are one shared setting.
// - Active acceleration unit picks time or rate; one common object exposed.
// - Unit select 0 means ms, 1 means command units per s squared.
// - Per-mode in csp/csv uses the quick stop deceleration object.
module sqs_quick_stop #(
  parameter int TIME_W = 16,
  parameter int RATE_W = 32
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic quick_stop_n,
  input wire logic enable_operation,
  input wire logic disable_voltage,
  input wire logic forced_stop_input_two,
  input wire logic forced_stop_decel_enable,
  input wire logic accel_unit_select,
  input wire sqs_pkg::sqs_mode_type mode,
  input wire sqs_pkg::sqs_event_type events,
  input wire logic method_wr,
  input wire logic [2:0] method_wdata,
  input wire logic time_const_wr,
  input wire logic [TIME_W-1:0] time_const_wdata,
  input wire logic rate_wr,
  input wire logic [RATE_W-1:0] rate_wdata,
  output sqs_pkg::sqs_pds_type pds_state,
  output sqs_pkg::sqs_drive_type drive,
  output logic [2:0] quick_stop_method_select,
  output logic [TIME_W-1:0] forced_stop_decel_time_const,
  output logic [RATE_W-1:0] forced_stop_decel_rate,
  output logic [RATE_W-1:0] common_decel_value,
  output logic common_decel_is_rate
);
`include "sqs_map.svh"

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [2:0] em2_sync;
    logic em2_stable;
    sqs_pkg::sqs_pds_type pds;
    logic stopping;
    logic hold_after;
    logic fault_path;
    sqs_pkg::sqs_decel_type decel_src;
    logic dyn_brake;
    logic servo_on;
    logic [2:0] method;
    logic [TIME_W-1:0] time_const;
    logic [RATE_W-1:0] rate;
  } sqs_state_type;

  sqs_state_type r;
  sqs_state_type next_r;

  logic em2_active;
  logic code_valid;
  logic brake_now;
  logic hold_code;
  logic per_mode;

  // The EM2 pin is low-active; a change counts once stages two and three agree.
  assign em2_active = ~r.em2_stable;

  // Reject writes of codes that the drive does not decode.
  assign code_valid = (method_wdata == `SQS_CODE_DYN_BRAKE) ||
                      (method_wdata == `SQS_CODE_MODE_OFF) ||
                      (method_wdata == `SQS_CODE_QS_OFF) ||
                      (method_wdata == `SQS_CODE_MODE_HOLD) ||
                      (method_wdata == `SQS_CODE_QS_HOLD);

  // Stop method decision; the brake conditions are checked first.
  always_comb begin
    brake_now = !forced_stop_decel_enable ||
                mode == sqs_pkg::SQS_CST || mode == sqs_pkg::SQS_PROFILE_TORQUE ||
                mode == sqs_pkg::SQS_CONT_TO_TORQUE ||
                events.command_stop ||
                (!em2_active && r.method == `SQS_CODE_DYN_BRAKE);
    hold_code = !em2_active && (r.method == `SQS_CODE_MODE_HOLD ||
                r.method == `SQS_CODE_QS_HOLD);
    per_mode = !em2_active && (r.method == `SQS_CODE_MODE_OFF ||
               r.method == `SQS_CODE_MODE_HOLD) &&
               mode != sqs_pkg::SQS_CSP && mode != sqs_pkg::SQS_CSV;
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  // One process holds the whole sequence so that stop, hold and fault paths
  // can never disagree about which deceleration is in charge.
  always_comb begin
    next_r = r;
    next_r.em2_sync = {r.em2_sync[1:0], forced_stop_input_two};
    if (r.em2_sync[2] == r.em2_sync[1]) begin
      next_r.em2_stable = r.em2_sync[2];
    end
    // One setting backs both the parameter and the option code object.
    if (method_wr && code_valid) begin
      next_r.method = method_wdata;
    end
    if (time_const_wr) begin
      next_r.time_const = time_const_wdata;
    end
    if (rate_wr) begin
      next_r.rate = rate_wdata;
    end
    case (r.pds)
      sqs_pkg::SQS_SWITCH_ON_DISABLED: begin
        next_r.dyn_brake = 1'b0;
        if (enable_operation && quick_stop_n && !em2_active) begin
          next_r.pds = sqs_pkg::SQS_OPERATION_ENABLED;
          next_r.servo_on = 1'b1;
        end
      end
      sqs_pkg::SQS_OPERATION_ENABLED: begin
        if (disable_voltage) begin
          next_r.pds = sqs_pkg::SQS_SWITCH_ON_DISABLED;
          next_r.servo_on = 1'b0;
        end else if (!quick_stop_n || em2_active) begin
          if (brake_now) begin
            next_r.pds = sqs_pkg::SQS_SWITCH_ON_DISABLED;
            next_r.servo_on = 1'b0;
            next_r.dyn_brake = 1'b1;
          end else begin
            next_r.pds = sqs_pkg::SQS_QUICK_STOP_ACTIVE;
            next_r.stopping = 1'b1;
            next_r.hold_after = hold_code;
            next_r.decel_src = per_mode ? sqs_pkg::SQS_DEC_PER_MODE :
                               sqs_pkg::SQS_DEC_QUICK_STOP;
          end
        end
      end
      sqs_pkg::SQS_QUICK_STOP_ACTIVE: begin
        if (r.stopping) begin
          if (events.command_stop) begin
            next_r.pds = sqs_pkg::SQS_SWITCH_ON_DISABLED;
            next_r.stopping = 1'b0;
            next_r.servo_on = 1'b0;
            next_r.dyn_brake = 1'b1;
            next_r.decel_src = sqs_pkg::SQS_DEC_NONE;
          end else if (events.fsd_alarm) begin
            next_r.pds = sqs_pkg::SQS_FAULT_REACTION_ACTIVE;
            next_r.hold_after = 1'b0;
            next_r.decel_src = sqs_pkg::SQS_DEC_QUICK_STOP;
          end else if (events.motor_stopped) begin
            next_r.stopping = 1'b0;
            next_r.decel_src = sqs_pkg::SQS_DEC_NONE;
            if (!r.hold_after) begin
              next_r.pds = sqs_pkg::SQS_SWITCH_ON_DISABLED;
              next_r.servo_on = 1'b0;
            end
          end else if (events.qs_warning) begin
            next_r.hold_after = 1'b0;
            next_r.decel_src = sqs_pkg::SQS_DEC_WARNING;
          end else if (events.fsd_warning) begin
            next_r.hold_after = 1'b0;
            next_r.decel_src = sqs_pkg::SQS_DEC_QUICK_STOP;
          end
        end else if (disable_voltage || em2_active) begin
          next_r.pds = sqs_pkg::SQS_SWITCH_ON_DISABLED;
          next_r.servo_on = 1'b0;
        end else if (enable_operation && quick_stop_n) begin
          next_r.pds = sqs_pkg::SQS_OPERATION_ENABLED;
        end
      end
      sqs_pkg::SQS_FAULT_REACTION_ACTIVE: begin
        if (events.motor_stopped) begin
          next_r.pds = sqs_pkg::SQS_SWITCH_ON_DISABLED;
          next_r.stopping = 1'b0;
          next_r.servo_on = 1'b0;
          next_r.decel_src = sqs_pkg::SQS_DEC_NONE;
        end
      end
      default: begin
        next_r.pds = sqs_pkg::SQS_SWITCH_ON_DISABLED;
        next_r.servo_on = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  // The EM2 chain resets to the released (high) level so reset never stops.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      r <= '0;
      r.em2_sync <= 3'h7;
      r.em2_stable <= 1'b1;
      r.pds <= sqs_pkg::SQS_SWITCH_ON_DISABLED;
      r.decel_src <= sqs_pkg::SQS_DEC_NONE;
      r.method <= `SQS_METHOD_RESET;
      r.time_const <= TIME_W'(`SQS_TIME_CONST_RESET_MS);
      r.rate <= RATE_W'(`SQS_DECEL_RATE_RESET);
    end else begin
      r <= next_r;
    end
  end

  // Outputs other than the common object all come from the state register.
  assign pds_state = r.pds;
  assign quick_stop_method_select = r.method;
  assign forced_stop_decel_time_const = r.time_const;
  assign forced_stop_decel_rate = r.rate;
  assign drive.servo_on = r.servo_on;
  assign drive.dyn_brake = r.dyn_brake;
  assign drive.decelerating = r.stopping;
  assign drive.zero_motion = (r.pds == sqs_pkg::SQS_QUICK_STOP_ACTIVE) && !r.stopping;
  assign drive.decel_src = r.decel_src;

  // A single object shows whichever setting the unit selection makes active.
  assign common_decel_is_rate = (accel_unit_select == `SQS_UNIT_RATE);
  assign common_decel_value = common_decel_is_rate ? r.rate :
                              RATE_W'(r.time_const);

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_ignore_outside_oe;
    @(posedge ref_clk) disable iff (rst)
    (r.pds == sqs_pkg::SQS_SWITCH_ON_DISABLED) |=> (r.pds != sqs_pkg::SQS_QUICK_STOP_ACTIVE);
  endproperty
  a_ignore_outside_oe: assert property (p_ignore_outside_oe) else $error("quick stop outside OE");

  property p_brake_when_disabled;
    @(posedge ref_clk) disable iff (rst)
    (r.pds == sqs_pkg::SQS_OPERATION_ENABLED && !disable_voltage && !quick_stop_n &&
     !forced_stop_decel_enable) |=> (r.dyn_brake && !r.servo_on);
  endproperty
  a_brake_when_disabled: assert property (p_brake_when_disabled) else $error("no brake");

  property p_torque_brake;
    @(posedge ref_clk) disable iff (rst)
    (r.pds == sqs_pkg::SQS_OPERATION_ENABLED && !disable_voltage && !quick_stop_n &&
     mode == sqs_pkg::SQS_CST) |=> (r.pds == sqs_pkg::SQS_SWITCH_ON_DISABLED);
  endproperty
  a_torque_brake: assert property (p_torque_brake) else $error("torque mode decelerated");

  property p_alarm_fault;
    @(posedge ref_clk) disable iff (rst)
    (r.pds == sqs_pkg::SQS_QUICK_STOP_ACTIVE && r.stopping && events.fsd_alarm &&
     !events.command_stop) |=> (r.pds == sqs_pkg::SQS_FAULT_REACTION_ACTIVE);
  endproperty
  a_alarm_fault: assert property (p_alarm_fault) else $error("alarm missed");

  property p_warning_stays;
    @(posedge ref_clk) disable iff (rst)
    (r.pds == sqs_pkg::SQS_QUICK_STOP_ACTIVE && r.stopping && events.fsd_warning &&
     !events.fsd_alarm && !events.command_stop && !events.motor_stopped &&
     !events.qs_warning) |=> (r.pds == sqs_pkg::SQS_QUICK_STOP_ACTIVE && !r.hold_after);
  endproperty
  a_warning_stays: assert property (p_warning_stays) else $error("warning left QSA");

  property p_cmd_stop_wins;
    @(posedge ref_clk) disable iff (rst)
    (r.pds == sqs_pkg::SQS_QUICK_STOP_ACTIVE && r.stopping && events.command_stop)
    |=> (r.dyn_brake && !r.servo_on);
  endproperty
  a_cmd_stop_wins: assert property (p_cmd_stop_wins) else $error("command stop lost");

  property p_method_valid;
    @(posedge ref_clk) disable iff (rst)
    (r.method == 3'h0 || r.method == 3'h1 || r.method == 3'h2 || r.method == 3'h5 ||
     r.method == 3'h6);
  endproperty
  a_method_valid: assert property (p_method_valid) else $error("bad method code");

  property p_hold_zero;
    @(posedge ref_clk) disable iff (rst)
    (drive.zero_motion && !(enable_operation && quick_stop_n) && !disable_voltage &&
     !em2_active)
    |=> (r.pds == sqs_pkg::SQS_QUICK_STOP_ACTIVE && r.servo_on);
  endproperty
  a_hold_zero: assert property (p_hold_zero) else $error("hold lost");

  c_qs_stop: cover property (@(posedge ref_clk) disable iff (rst)
    r.pds == sqs_pkg::SQS_QUICK_STOP_ACTIVE ##1 r.pds == sqs_pkg::SQS_SWITCH_ON_DISABLED);
  c_fault: cover property (@(posedge ref_clk) disable iff (rst)
    r.pds == sqs_pkg::SQS_FAULT_REACTION_ACTIVE);
  c_hold: cover property (@(posedge ref_clk) disable iff (rst) drive.zero_motion);
endmodule

// file: core/sqs_map.svh
// Purpose: Constants for the quick stop control block.
// Assumes: 50 MHz reference clock.
// Notes: Times are in their own unit; cycle counts derive from them.
`ifndef SQS_MAP_SVH
`define SQS_MAP_SVH
// ----------------------------------------------------------------------
// Method codes and reset values
// ----------------------------------------------------------------------
`define SQS_CODE_DYN_BRAKE 3'h0
`define SQS_CODE_MODE_OFF 3'h1
`define SQS_CODE_QS_OFF 3'h2
`define SQS_CODE_MODE_HOLD 3'h5
`define SQS_CODE_QS_HOLD 3'h6
`define SQS_METHOD_RESET 3'h2
`define SQS_TIME_CONST_RESET_MS 16'h0064
`define SQS_DECEL_RATE_RESET 32'h0000_0000
`define SQS_UNIT_MS 1'h0
`define SQS_UNIT_RATE 1'h1
// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SQS_CLK_HZ 50000000
`define SQS_MS_CYCLES (`SQS_CLK_HZ / 1000)
`endif

// file: core/sqs_pkg.sv
// Purpose: Types for the quick stop control block.
// Assumes: Nothing beyond the map header.
// Notes: Mode list covers every mode the drive can run.
package sqs_pkg;
  // Drive state machine states that this block reports.
  typedef enum logic [2:0] {
    SQS_SWITCH_ON_DISABLED,
    SQS_OPERATION_ENABLED,
    SQS_QUICK_STOP_ACTIVE,
    SQS_FAULT_REACTION_ACTIVE,
    SQS_OTHER
  } sqs_pds_type;

  // Active control mode.
  typedef enum logic [3:0] {
    SQS_CSP, SQS_CSV, SQS_CST,
    SQS_PROFILE_POSITION, SQS_PROFILE_VELOCITY, SQS_PROFILE_TORQUE,
    SQS_POINT_TABLE, SQS_JOG, SQS_HOMING, SQS_CONT_TO_TORQUE
  } sqs_mode_type;

  // Which deceleration source drives the stop.
  typedef enum logic [1:0] {
    SQS_DEC_NONE, SQS_DEC_QUICK_STOP, SQS_DEC_PER_MODE, SQS_DEC_WARNING
  } sqs_decel_type;

  // Events seen on the drive side.
  typedef struct packed {
    logic fsd_alarm;
    logic fsd_warning;
    logic qs_warning;
    logic command_stop;
    logic motor_stopped;
  } sqs_event_type;

  // Outputs toward the motion generator and power stage.
  typedef struct packed {
    logic servo_on;
    logic dyn_brake;
    logic decelerating;
    logic zero_motion;
    sqs_decel_type decel_src;
  } sqs_drive_type;
endpackage

// file: sim/sqs_controller_model.sv
// Purpose: Network controller model that issues controlword commands.
// Assumes: The drive samples the controlword on the rising edge of ref_clk.
// Notes: Position follow-up is reduced to a flag; no motion is modelled.
module sqs_controller_model #(
  parameter bit FOLLOW_UP_CAPABLE = 1'b1
) (
  input wire logic ref_clk,
  output logic quick_stop_n,
  output logic enable_operation,
  output logic disable_voltage
);
  timeunit 1ns;
  timeprecision 100ps;
  logic follow_up_done;

  // ----------------------------------------------------------------------
  // Controlword commands
  // ----------------------------------------------------------------------
  // Idle controller: quick stop released, operation not yet enabled.
  initial begin
    quick_stop_n = 1'b1;
    enable_operation = 1'b0;
    disable_voltage = 1'b0;
    follow_up_done = 1'b0;
  end

  // Bits change just after an edge so the drive never samples a half-made word.
  task automatic command(input logic qs_n, input logic en);
    @(posedge ref_clk);
    #1;
    quick_stop_n = qs_n;
    enable_operation = en;
    if (!qs_n) begin
      follow_up_done = 1'b0;
    end
  endtask

  // Target and offset are copied from the actual position before release,
  // otherwise the motor could jump on release.
  task automatic release_stop();
    @(posedge ref_clk);
    #1;
    follow_up_done = 1'b1;
    command(1'b1, 1'b1);
  endtask

  // Voltage switch-off request, held as a level until it is withdrawn.
  task automatic voltage_off(input logic dv);
    @(posedge ref_clk);
    #1;
    disable_voltage = dv;
  endtask

  // Without follow-up the holding codes are unsafe in cyclic position mode.
  function automatic bit hold_code_allowed(input sqs_pkg::sqs_mode_type m,
                                           input logic [2:0] code);
    return FOLLOW_UP_CAPABLE || m != sqs_pkg::SQS_CSP || !(code == 3'h5 || code == 3'h6);
  endfunction
endmodule

// file: sim/tb_servo_quick_stop.sv
// Purpose: Self-checking bench for the quick stop control block.
// Assumes: State changes appear one cycle after their cause.
// Notes: Every state change is compared against a queue of expected states.
module tb_servo_quick_stop;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk, rst, quick_stop_n, enable_operation, disable_voltage;
  logic forced_stop_input_two, forced_stop_decel_enable, accel_unit_select;
  logic method_wr, time_const_wr, rate_wr, common_decel_is_rate;
  logic [2:0] method_wdata, quick_stop_method_select;
  logic [15:0] time_const_wdata, forced_stop_decel_time_const;
  logic [31:0] rate_wdata, forced_stop_decel_rate, common_decel_value;
  sqs_pkg::sqs_mode_type mode;
  sqs_pkg::sqs_event_type events;
  sqs_pkg::sqs_pds_type pds_state, last_pds;
  sqs_pkg::sqs_drive_type drive;
  sqs_pkg::sqs_pds_type exp_q[$];
  int miscompares, compares;
  bit armed;

  sqs_quick_stop dut (.ref_clk(ref_clk), .rst(rst), .quick_stop_n(quick_stop_n),
    .enable_operation(enable_operation), .disable_voltage(disable_voltage),
    .forced_stop_input_two(forced_stop_input_two),
    .forced_stop_decel_enable(forced_stop_decel_enable),
    .accel_unit_select(accel_unit_select), .mode(mode), .events(events),
    .method_wr(method_wr), .method_wdata(method_wdata), .time_const_wr(time_const_wr),
    .time_const_wdata(time_const_wdata), .rate_wr(rate_wr), .rate_wdata(rate_wdata),
    .pds_state(pds_state), .drive(drive), .quick_stop_method_select(quick_stop_method_select),
    .forced_stop_decel_time_const(forced_stop_decel_time_const),
    .forced_stop_decel_rate(forced_stop_decel_rate),
    .common_decel_value(common_decel_value), .common_decel_is_rate(common_decel_is_rate));
  sqs_controller_model ctl (.ref_clk(ref_clk), .quick_stop_n(quick_stop_n),
    .enable_operation(enable_operation), .disable_voltage(disable_voltage));

  // ----------------------------------------------------------------------
  // Clock, comparison and state monitor
  // ----------------------------------------------------------------------
  // Free-running 50 MHz clock.
  initial ref_clk = 1'b0;
  always #10 ref_clk = ~ref_clk;

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Sampled on the falling edge, where the state launched by the rising edge has settled.
  always @(negedge ref_clk) begin
    if (armed && pds_state !== last_pds) begin
      if (exp_q.size() == 0) check("pds_unexpected", {29'h0, pds_state}, {29'h0, last_pds});
      else check("pds_state", {29'h0, pds_state}, {29'h0, exp_q.pop_front()});
    end
    last_pds = pds_state;
  end

  // The run is short; a hang is cut off long before the cycle budget.
  initial begin
    #400000;
    miscompares++;
    end_of_test();
  end

  // ----------------------------------------------------------------------
  // Stimulus tasks
  // ----------------------------------------------------------------------
  // Notes the expected state and waits a bounded time for it.
  task automatic go(input sqs_pkg::sqs_pds_type s);
    int n;
    exp_q.push_back(s);
    n = 0;
    while (pds_state !== s && n < 40) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (n == 40) check("pds_wait", 32'h1, 32'h0);
  endtask

  task automatic wr_method(input logic [2:0] v, input logic [2:0] exp);
    @(posedge ref_clk);
    #1;
    method_wr = 1'b1;
    method_wdata = v;
    @(posedge ref_clk);
    #1;
    method_wr = 1'b0;
    check("method", {29'h0, quick_stop_method_select}, {29'h0, exp});
  endtask

  task automatic to_oe(input logic [2:0] code, input sqs_pkg::sqs_mode_type m);
    wr_method(code, code);
    mode = m;
    if (pds_state !== sqs_pkg::SQS_OPERATION_ENABLED) begin
      ctl.command(1'b1, 1'b1);
      go(sqs_pkg::SQS_OPERATION_ENABLED);
    end
  endtask

  task automatic stop_to_sod();
    events.motor_stopped = 1'b1;
    go(sqs_pkg::SQS_SWITCH_ON_DISABLED);
    check("servo_on", {31'h0, drive.servo_on}, 32'h0);
    events = '0;
  endtask

  // Kind 0 decelerates to servo-off, 1 brakes at once, 2 holds servo-on.
  // Kind 3 leaves the drive decelerating so that an event can be injected.
  task automatic qs_run(input logic [2:0] code, input sqs_pkg::sqs_mode_type m,
                        input int kind, input sqs_pkg::sqs_decel_type src);
    if (!ctl.hold_code_allowed(m, code)) return;
    to_oe(code, m);
    ctl.command(1'b0, 1'b1);
    if (kind == 1) begin
      go(sqs_pkg::SQS_SWITCH_ON_DISABLED);
      check("dyn_brake", {31'h0, drive.dyn_brake}, 32'h1);
      return;
    end
    go(sqs_pkg::SQS_QUICK_STOP_ACTIVE);
    check("decelerating", {31'h0, drive.decelerating}, 32'h1);
    check("decel_src", {30'h0, drive.decel_src}, {30'h0, src});
    if (kind == 0) begin
      stop_to_sod();
      return;
    end
    if (kind == 3) return;
    events.motor_stopped = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    check("hold_state", {29'h0, pds_state}, {29'h0, sqs_pkg::SQS_QUICK_STOP_ACTIVE});
    check("zero_motion", {31'h0, drive.zero_motion}, 32'h1);
    events = '0;
    ctl.release_stop();
    go(sqs_pkg::SQS_OPERATION_ENABLED);
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    logic [15:0] t;
    logic [31:0] r;
    rst = 1'b1;
    forced_stop_input_two = 1'b1;
    forced_stop_decel_enable = 1'b1;
    accel_unit_select = 1'b0;
    {method_wr, time_const_wr, rate_wr} = 3'h0;
    method_wdata = 3'h0;
    time_const_wdata = 16'h0;
    rate_wdata = 32'h0;
    mode = sqs_pkg::SQS_CSP;
    events = '0;
    void'($urandom(32'hacdb296d));
    repeat (8) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    check("method_rst", {29'h0, quick_stop_method_select}, 32'h2);
    check("time_rst", {16'h0, forced_stop_decel_time_const}, 32'h64);
    check("rate_rst", forced_stop_decel_rate, 32'h0);
    check("common_rst", common_decel_value, 32'h64);
    check("is_rate_rst", {31'h0, common_decel_is_rate}, 32'h0);
    last_pds = pds_state;
    armed = 1'b1;
    ctl.command(1'b0, 1'b0);
    repeat (4) @(posedge ref_clk);
    #1;
    check("pds_idle", {29'h0, pds_state}, {29'h0, sqs_pkg::SQS_SWITCH_ON_DISABLED});
    for (int m = 0; m < 9; m++) begin
      if (m == 2 || m == 5) qs_run(3'h2, sqs_pkg::sqs_mode_type'(m), 1, sqs_pkg::SQS_DEC_NONE);
      else qs_run(3'h2, sqs_pkg::sqs_mode_type'(m), 0, sqs_pkg::SQS_DEC_QUICK_STOP);
    end
    qs_run(3'h2, sqs_pkg::SQS_CONT_TO_TORQUE, 1, sqs_pkg::SQS_DEC_NONE);
    qs_run(3'h0, sqs_pkg::SQS_CSP, 1, sqs_pkg::SQS_DEC_NONE);
    qs_run(3'h1, sqs_pkg::SQS_CSV, 0, sqs_pkg::SQS_DEC_QUICK_STOP);
    qs_run(3'h1, sqs_pkg::SQS_PROFILE_POSITION, 0, sqs_pkg::SQS_DEC_PER_MODE);
    qs_run(3'h5, sqs_pkg::SQS_PROFILE_VELOCITY, 2, sqs_pkg::SQS_DEC_PER_MODE);
    qs_run(3'h6, sqs_pkg::SQS_CSP, 2, sqs_pkg::SQS_DEC_QUICK_STOP);
    ctl.command(1'b1, 1'b0);
    ctl.voltage_off(1'b1);
    go(sqs_pkg::SQS_SWITCH_ON_DISABLED);
    check("servo_off_dv", {31'h0, drive.servo_on}, 32'h0);
    ctl.voltage_off(1'b0);
    forced_stop_decel_enable = 1'b0;
    qs_run(3'h6, sqs_pkg::SQS_JOG, 1, sqs_pkg::SQS_DEC_NONE);
    forced_stop_decel_enable = 1'b1;
    events.command_stop = 1'b1;
    qs_run(3'h2, sqs_pkg::SQS_HOMING, 1, sqs_pkg::SQS_DEC_NONE);
    events = '0;
    qs_run(3'h2, sqs_pkg::SQS_POINT_TABLE, 3, sqs_pkg::SQS_DEC_QUICK_STOP);
    events.fsd_alarm = 1'b1;
    go(sqs_pkg::SQS_FAULT_REACTION_ACTIVE);
    stop_to_sod();
    qs_run(3'h6, sqs_pkg::SQS_PROFILE_POSITION, 3, sqs_pkg::SQS_DEC_QUICK_STOP);
    events.fsd_warning = 1'b1;
    @(posedge ref_clk);
    #1;
    check("warn_qsa", {29'h0, pds_state}, {29'h0, sqs_pkg::SQS_QUICK_STOP_ACTIVE});
    stop_to_sod();
    qs_run(3'h6, sqs_pkg::SQS_PROFILE_POSITION, 3, sqs_pkg::SQS_DEC_QUICK_STOP);
    events.qs_warning = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    check("warn_src", {30'h0, drive.decel_src}, {30'h0, sqs_pkg::SQS_DEC_WARNING});
    stop_to_sod();
    to_oe(3'h6, sqs_pkg::SQS_PROFILE_VELOCITY);
    forced_stop_input_two = 1'b0;
    go(sqs_pkg::SQS_QUICK_STOP_ACTIVE);
    ctl.command(1'b0, 1'b1);
    forced_stop_input_two = 1'b1;
    stop_to_sod();
    wr_method(3'h3, 3'h6);
    wr_method(3'h7, 3'h6);
    for (int i = 0; i < 4; i++) begin
      t = 16'($urandom);
      r = $urandom;
      @(posedge ref_clk);
      #1;
      {time_const_wr, time_const_wdata, rate_wr, rate_wdata} = {1'b1, t, 1'b1, r};
      accel_unit_select = i[0];
      @(posedge ref_clk);
      #1;
      {time_const_wr, rate_wr} = 2'h0;
      @(posedge ref_clk);
      #1;
      check("time_const", {16'h0, forced_stop_decel_time_const}, {16'h0, t});
      check("rate", forced_stop_decel_rate, r);
      check("common", common_decel_value, i[0] ? r : {16'h0, t});
      check("is_rate", {31'h0, common_decel_is_rate}, {31'h0, i[0]});
    end
    end_of_test();
  end
endmodule
